//--- core/sip_irq_persist_cfg.v
// Interrupt persistence filter and miscellaneous configuration of a light and proximity sensor.
`timescale 1ns/1ps
`default_nettype none
`include "sip_regs.vh"

module sip_irq_persist_cfg #(
  parameter WAIT_STEP_CYC = (`SIP_WAIT_STEP_NS + `SIP_CLK_PERIOD_NS - 1) / `SIP_CLK_PERIOD_NS,
  parameter LED_HALF_CYC  = 4
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Register port
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Interrupt enables from the enable register, and the light gain select
  input  wire        prox_irq_mask,
  input  wire        light_irq_mask,
  input  wire [1:0]  light_gain_sel,
  // Light result and thresholds
  input  wire        light_done,
  input  wire [15:0] ch0_result,
  input  wire [15:0] light_thr_low,
  input  wire [15:0] light_thr_high,
  // Proximity result and thresholds
  input  wire        prox_done,
  input  wire [15:0] prox_result,
  input  wire [15:0] prox_thr_low,
  input  wire [15:0] prox_thr_high,
  // Wait timer
  input  wire        wait_start,
  input  wire [7:0]  wait_period,
  output wire        wait_busy,
  // LED driver and light gain scaling
  input  wire        prox_accum_start,
  output wire        led_sink_pin,
  output wire        led_drive_reduce,
  output wire        light_gain_scale_low,
  output wire        led_pulse_busy,
  // Interrupt events
  output wire        prox_irq_event,
  output wire        light_irq_event
);

  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_core_n = rst_s2_reg;

  reg  [7:0] persist_reg;
  reg  [7:0] misc_cfg_reg;
  reg  [7:0] pulse_cnt_reg;

  reg  [5:0] light_trip;
  wire [3:0] prox_persist_sel  = persist_reg[`SIP_PROX_SEL_HI:`SIP_PROX_SEL_LO];
  wire [3:0] light_persist_sel = persist_reg[`SIP_LIGHT_SEL_HI:`SIP_LIGHT_SEL_LO];
  wire       wait_stretch      = misc_cfg_reg[`SIP_WAIT_STRETCH_BIT];

  wire       prox_out;
  wire       light_out;
  wire       prox_trip;
  wire       light_trip_ev;
  wire       led_on;

  reg  [8:0]  wait_steps_reg;
  reg  [3:0]  wait_mult_reg;
  reg  [31:0] wait_tick_reg;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Register writes; reserved configuration bits are held at zero.
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      persist_reg   <= `SIP_PERSIST_RST;
      misc_cfg_reg  <= `SIP_MISC_CFG_RST;
      pulse_cnt_reg <= `SIP_PULSE_CNT_RST;
    end else if (reg_wr) begin
      if (reg_addr == `SIP_ADDR_PERSIST) begin
        persist_reg <= reg_wdata;
      end else if (reg_addr == `SIP_ADDR_MISC_CFG) begin
        misc_cfg_reg <= reg_wdata & `SIP_MISC_CFG_MASK;
      end else if (reg_addr == `SIP_ADDR_PULSE_CNT) begin
        pulse_cnt_reg <= reg_wdata;
      end
    end
  end

  always @* begin
    if (reg_addr == `SIP_ADDR_PERSIST) begin
      reg_rdata = persist_reg;
    end else if (reg_addr == `SIP_ADDR_MISC_CFG) begin
      reg_rdata = misc_cfg_reg;
    end else if (reg_addr == `SIP_ADDR_PULSE_CNT) begin
      reg_rdata = pulse_cnt_reg;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // Light code to required run length.
  always @* begin
    if (light_persist_sel <= `SIP_LIGHT_DIRECT_MAX) begin
      light_trip = {2'b00, light_persist_sel};
    end else begin
      light_trip = `SIP_LIGHT_STEP * {2'b00, light_persist_sel - `SIP_LIGHT_OFFSET};
    end
  end

  assign light_out = (ch0_result < light_thr_low) || (ch0_result > light_thr_high);
  assign prox_out  = (prox_result < prox_thr_low) || (prox_result > prox_thr_high);

  sip_persist_filter #(.CNT_W(4)) u_prox_filter (
    .core_clk     (core_clk),
    .rst_n        (rst_core_n),
    .result_valid (prox_done),
    .out_of_range (prox_out),
    .trip_count   (prox_persist_sel),
    .trip         (prox_trip)
  );

  sip_persist_filter #(.CNT_W(6)) u_light_filter (
    .core_clk     (core_clk),
    .rst_n        (rst_core_n),
    .result_valid (light_done),
    .out_of_range (light_out),
    .trip_count   (light_trip),
    .trip         (light_trip_ev)
  );

  assign prox_irq_event  = prox_trip && prox_irq_mask;
  assign light_irq_event = light_trip_ev && light_irq_mask;

  // Wait timer: wait_period is two's complement, so 256 minus the value gives the steps.
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      wait_steps_reg <= 9'h000;
      wait_mult_reg  <= 4'h0;
      wait_tick_reg  <= 32'h0000_0000;
    end else if (wait_start && !wait_busy) begin
      wait_steps_reg <= 9'h100 - {1'b0, wait_period};
      wait_mult_reg  <= wait_stretch ? `SIP_WAIT_MULT - 4'h1 : 4'h0;
      wait_tick_reg  <= 32'h0000_0000;
    end else if (wait_busy) begin
      if (wait_tick_reg == WAIT_STEP_CYC - 1) begin
        wait_tick_reg <= 32'h0000_0000;
        if (wait_steps_reg == 9'h001 && wait_mult_reg != 4'h0) begin
          wait_steps_reg <= 9'h100 - {1'b0, wait_period};
          wait_mult_reg  <= wait_mult_reg - 4'h1;
        end else begin
          wait_steps_reg <= wait_steps_reg - 9'h001;
        end
      end else begin
        wait_tick_reg <= wait_tick_reg + 32'h0000_0001;
      end
    end
  end

  assign wait_busy = (wait_steps_reg != 9'h000);

  sip_led_pulser #(.HALF_CYC(LED_HALF_CYC)) u_led_pulser (
    .core_clk    (core_clk),
    .rst_n       (rst_core_n),
    .start       (prox_accum_start),
    .pulse_count (pulse_cnt_reg),
    .led_on      (led_on),
    .busy        (led_pulse_busy)
  );

  // The pin sinks current while on; the reduced level goes to the analog driver.
  assign led_sink_pin         = led_on;
  assign led_drive_reduce     = misc_cfg_reg[`SIP_LED_REDUCE_BIT];
  assign light_gain_scale_low = misc_cfg_reg[`SIP_GAIN_SCALE_BIT] &&
                                (light_gain_sel <= 2'b01);

endmodule // sip_irq_persist_cfg
`default_nettype wire

//--- core/sip_led_pulser.v
// LED pulse train generator for the proximity accumulation state.
`timescale 1ns/1ps
`default_nettype none
`include "sip_regs.vh"

module sip_led_pulser #(
  parameter HALF_CYC = 4
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Control
  input  wire       start,
  input  wire [7:0] pulse_count,
  // Outputs
  output reg        led_on,
  output wire       busy
);

  reg [7:0] left_reg;
  reg [7:0] tick_reg;

  assign busy = (left_reg != 8'h00) || led_on;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_reg <= 8'h00;
      tick_reg <= 8'h00;
      led_on   <= 1'b0;
    end else if (start && !busy) begin
      left_reg <= pulse_count;
      tick_reg <= 8'h00;
    end else if (busy) begin
      if (tick_reg == HALF_CYC[7:0] - 8'h01) begin
        tick_reg <= 8'h00;
        if (led_on) begin
          led_on <= 1'b0;
        end else if (left_reg != 8'h00) begin
          led_on   <= 1'b1;
          left_reg <= left_reg - 8'h01;
        end
      end else begin
        tick_reg <= tick_reg + 8'h01;
      end
    end
  end

endmodule // sip_led_pulser
`default_nettype wire

//--- core/sip_persist_filter.v
// Consecutive out-of-range counter for one channel with a programmable trip count.
`timescale 1ns/1ps
`default_nettype none
`include "sip_regs.vh"

module sip_persist_filter #(
  parameter CNT_W = 6
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  // Result stream
  input  wire             result_valid,
  input  wire             out_of_range,
  input  wire [CNT_W-1:0] trip_count,
  // Event
  output reg              trip
);

  reg [CNT_W-1:0] run_reg;
  reg [CNT_W-1:0] run_next;
  reg             trip_next;

  always @* begin
    run_next  = run_reg;
    trip_next = 1'b0;
    if (result_valid) begin
      if (trip_count == {CNT_W{1'b0}}) begin
        trip_next = 1'b1;
        run_next  = {CNT_W{1'b0}};
      end else if (!out_of_range) begin
        run_next = {CNT_W{1'b0}};
      end else if (run_reg >= trip_count - 1'b1) begin
        trip_next = 1'b1;
        run_next  = trip_count;
      end else begin
        run_next = run_reg + 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= {CNT_W{1'b0}};
      trip    <= 1'b0;
    end else begin
      run_reg <= run_next;
      trip    <= trip_next;
    end
  end

endmodule // sip_persist_filter
`default_nettype wire

//--- core/sip_regs.vh
// Register map, field positions, reset values and timing constants of the persistence block.
`ifndef SIP_REGS_VH
`define SIP_REGS_VH

`define SIP_ADDR_PERSIST     5'h0C
`define SIP_ADDR_MISC_CFG    5'h0D
`define SIP_ADDR_PULSE_CNT   5'h0E

`define SIP_PERSIST_RST      8'h00
`define SIP_MISC_CFG_RST     8'h00
`define SIP_PULSE_CNT_RST    8'h00
`define SIP_MISC_CFG_MASK    8'h07

`define SIP_PROX_SEL_HI      7
`define SIP_PROX_SEL_LO      4
`define SIP_LIGHT_SEL_HI     3
`define SIP_LIGHT_SEL_LO     0
`define SIP_LED_REDUCE_BIT   0
`define SIP_WAIT_STRETCH_BIT 1
`define SIP_GAIN_SCALE_BIT   2

`define SIP_LIGHT_DIRECT_MAX 4'h3
`define SIP_LIGHT_OFFSET     4'h3
`define SIP_LIGHT_STEP       6'h05
`define SIP_WAIT_MULT        4'hC

`define SIP_WAIT_STEP_NS     2730000
`define SIP_CLK_PERIOD_NS    25
`define SIP_LED_REDUCE_DIV   4'h9

`endif

//--- verif/sip_host_model.sv
// Host processor model that writes and reads the configuration registers.
`timescale 1ns/1ps
`default_nettype none
module sip_host_model (
  input  wire logic       core_clk,
  output var  logic [4:0] reg_addr = 5'h00,
  output var  logic       reg_wr = 1'b0,
  output var  logic [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = (a == 5'h0D) ? (d & 8'h07) : d;
    reg_wr = 1'b1;
    @(negedge core_clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge core_clk) reg_addr = a;
    #1 d = reg_rdata;
  endtask
endmodule // sip_host_model
`default_nettype wire

//--- verif/sip_irq_persist_cfg_chk.sv
// Port assertions of the persistence block.
`timescale 1ns/1ps
`default_nettype none
module sip_irq_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       prox_irq_mask,
  input wire logic       light_irq_mask,
  input wire logic [1:0] light_gain_sel,
  input wire logic       prox_done,
  input wire logic       led_sink_pin,
  input wire logic       led_drive_reduce,
  input wire logic       light_gain_scale_low,
  input wire logic       prox_irq_event,
  input wire logic       light_irq_event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_prox_mask: assert property (
    prox_irq_event |-> prox_irq_mask) else $error("prox masked");
  a_light_mask: assert property (
    light_irq_event |-> light_irq_mask) else $error("light masked");
  a_prox_cause: assert property (
    prox_irq_event |-> $past(prox_done)) else $error("prox no result");
  a_prox_every: assert property (
    prox_done && reg_addr == 5'h0C && reg_rdata[7:4] == 4'h0 ##1 prox_irq_mask
    |-> prox_irq_event) else $error("prox code zero");
  a_cfg_rsvd: assert property (
    reg_addr == 5'h0D |-> reg_rdata[7:3] == 5'h00) else $error("config reserved");
  a_led_reduce: assert property (
    reg_addr == 5'h0D |-> led_drive_reduce == reg_rdata[0]) else $error("drive reduce");
  a_gain_scale: assert property (
    reg_addr == 5'h0D && $stable(light_gain_sel) |-> light_gain_scale_low ==
    (reg_rdata[2] && !light_gain_sel[1])) else $error("gain scale");
  a_led_len: assert property (
    $rose(led_sink_pin) |-> led_sink_pin[*4] ##1 !led_sink_pin) else $error("led pulse");
  c_prox_evt: cover property (prox_irq_event);
  c_light_evt: cover property (light_irq_event);
  c_led_pulse: cover property ($fell(led_sink_pin));
endmodule // sip_irq_chk
bind sip_irq_persist_cfg sip_irq_chk u_chk (.*);
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench of the persistence block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0, rst_n = 1'b0, light_done = 1'b0, prox_done = 1'b0;
  logic        prox_irq_mask = 1'b1, light_irq_mask = 1'b1, wait_start = 1'b0;
  logic        prox_accum_start = 1'b0;
  logic [1:0]  light_gain_sel = 2'h0;
  logic [15:0] v = 16'h0000;
  logic [7:0]  wp = 8'hFE;
  wire  [4:0]  reg_addr;
  wire  [7:0]  reg_wdata, reg_rdata;
  wire         reg_wr, wait_busy, led_sink_pin, led_drive_reduce, light_gain_scale_low;
  wire         led_pulse_busy, prox_irq_event, light_irq_event;
  int          n_errors = 0, cmp_count = 0;
  always #12.5 core_clk = ~core_clk;
  sip_host_model host (.*);
  sip_irq_persist_cfg #(.WAIT_STEP_CYC(4)) DUT (.*, .ch0_result(v), .prox_result(v),
    .light_thr_low(16'h0100), .light_thr_high(16'h0F00), .prox_thr_low(16'h0100),
    .prox_thr_high(16'h0F00), .wait_period(wp));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("Error %s expected %h seen %h", nm, exp, got);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk("reg_rdata", d, exp);
  endtask
  task automatic res(input logic p, input logic [15:0] r, input logic exp);
    @(negedge core_clk);
    {prox_done, light_done} = {p, !p};
    v = r;
    @(negedge core_clk);
    {prox_done, light_done} = 2'b00;
    chk("irq_event", {7'h00, p ? prox_irq_event : light_irq_event}, {7'h00, exp});
  endtask
  task automatic run(input logic p, input int c);
    int n;
    n = (p || c < 4) ? c : 5 * (c - 3);
    host.wr(5'h0C, p ? 8'(c << 4) : 8'(c));
    res(p, 16'h0800, c == 0);
    repeat (n - 1) res(p, 16'h1000, 1'b0);
    if (c != 0) res(p, 16'h0F00, 1'b0);
    repeat (n - 1) res(p, 16'h00FF, 1'b0);
    if (c != 0) res(p, 16'h0F01, 1'b1);
    if (c != 0) res(p, 16'hFFFF, 1'b1);
  endtask
  task automatic t_regs();
    host.wr(5'h0E, 8'hA5);
    host.wr(5'h1F, 8'h5A);
    rchk(5'h1F, 8'h00);
    rchk(5'h0E, 8'hA5);
    host.wr(5'h0D, 8'h05);
    rchk(5'h0D, 8'h05);
    chk("drive_reduce", {7'h00, led_drive_reduce}, 8'h01);
    chk("gain_scale", {7'h00, light_gain_scale_low}, 8'h01);
  endtask
  task automatic t_persist();
    for (int c = 0; c < 16; c++) begin
      run(1'b0, c);
      run(1'b1, c);
    end
    host.wr(5'h0C, 8'h00);
    {prox_irq_mask, light_irq_mask} = 2'b00;
    res(1'b1, 16'h0800, 1'b0);
    res(1'b0, 16'h1000, 1'b0);
    {prox_irq_mask, light_irq_mask} = 2'b11;
  endtask
  task automatic t_reset();
    @(negedge core_clk) rst_n = 1'b0;
    @(negedge core_clk) rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    rchk(5'h0C, 8'h00);
    rchk(5'h0D, 8'h00);
    rchk(5'h0E, 8'h00);
    chk("drive_reduce", {7'h00, led_drive_reduce}, 8'h00);
  endtask
  task automatic cnt(input logic w, input logic [7:0] exp);
    int n;
    @(negedge core_clk);
    {wait_start, prox_accum_start} = {w, !w};
    @(negedge core_clk);
    {wait_start, prox_accum_start} = 2'b00;
    n = int'(w ? wait_busy : led_sink_pin);
    repeat (200) @(negedge core_clk) n += int'(w ? wait_busy : led_sink_pin);
    chk("high_cycles", 8'(n), exp);
  endtask
  task automatic t_timers();
    host.wr(5'h0E, 8'h03);
    cnt(1'b0, 8'h0C);
    host.wr(5'h0E, 8'h00);
    cnt(1'b0, 8'h00);
    host.wr(5'h0D, 8'h00);
    cnt(1'b1, 8'h08);
    host.wr(5'h0D, 8'h02);
    cnt(1'b1, 8'h60);
    host.wr(5'h0D, 8'h00);
    wp = 8'hFD;
    cnt(1'b1, 8'h0C);
  endtask
  task automatic final_report(input int extra);
    n_errors += extra;
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_regs();
    t_reset();
    t_persist();
    t_timers();
    final_report(0);
  end
  initial #1ms final_report(1);
endmodule // testbench
`default_nettype wire
